// ===== hdl/pin_mux_consts.svh
// Offsets, field positions and reset values of the pin-function selector.
// Assumes inclusion by bare name from the design module and the bench.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define ADDR_W          8
`define NPIN            17
`define NPULL           13

`define REG_CTRL_OFF    8'h00
`define REG_DATA_OFF    8'h04
`define REG_DIR_OFF     8'h08
`define REG_PULL_OFF    8'h0C
`define REG_LEVEL_OFF   8'h10
`define REG_STATUS_OFF  8'h14

`define CTRL_EXT_BUS    0
`define CTRL_HOLD       1
`define CTRL_READY      2
`define CTRL_CLKOUT     3
`define CTRL_WAVE_LO    4
`define CTRL_WAVE_HI    5
`define CTRL_W          6

`define PIN_P0_LSB      0
`define PIN_P1_0        8
`define PIN_HOLD_REQ    9
`define PIN_HOLD_ACK    10
`define PIN_READY       11
`define PIN_CLK         12
`define PIN_P9_LSB      13

`define CTRL_RST        6'h00
`define PIN_RST         17'h0_0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== hdl/pin_mux_pkg.sv
// Types shared by the pin-function selector.
// Assumes the constants header sits beside it.
package pin_mux_pkg;
	typedef enum logic [2:0] {
		FUNC_GPIO,
		FUNC_BUS,
		FUNC_HOLD_IN,
		FUNC_HOLD_ACK,
		FUNC_READY,
		FUNC_CLK,
		FUNC_WAVE
	} pin_func_t;
endpackage

// ===== hdl/bus_port_pin_function_select.sv
// Pin-function selector for the shared port pins, with an AXI4-Lite slave.
// Assumes pin inputs synchronous to aclk and a pad ring resolving out/oe.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

module bus_port_pin_function_select (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite slave
	input  wire logic [31:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [31:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Internal bus controller side
	input  wire logic [8:0]          bus_ad_out,
	input  wire logic                bus_ad_oe,
	output logic [8:0]               bus_ad_in,
	output logic                     hold_request,
	input  wire logic                hold_grant,
	output logic                     ext_ready,
	input  wire logic [7:0]          wave_in,
	// Pads
	input  wire logic [7:0]          port0_bits_in,
	output logic [7:0]               port0_bits_out,
	output logic [7:0]               port0_bits_oe,
	output logic [7:0]               port0_bits_pullup,
	input  wire logic                port1_bit0_in,
	output logic                     port1_bit0_out,
	output logic                     port1_bit0_oe,
	output logic                     port1_bit0_pullup,
	input  wire logic [3:0]          port3_bits_in,
	output logic [3:0]               port3_bits_out,
	output logic [3:0]               port3_bits_oe,
	output logic [3:0]               port3_bits_pullup,
	input  wire logic [3:0]          port9_bits_in,
	output logic [3:0]               port9_bits_out,
	output logic [3:0]               port9_bits_oe
);

	logic [`CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic [`NPIN-1:0]    data_q, data_d, dir_q, dir_d;
	logic [`NPULL-1:0]   pull_q, pull_d;
	logic [`ADDR_W-1:0]  waddr_q, waddr_d;
	logic [31:0]         wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]          wstrb_q, wstrb_d;
	logic                aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic                bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]         wmask;
	logic                aw_hs, w_hs, ar_hs, do_wr;

	logic [`NPIN-1:0]    pin_in, out_q, out_d, oe_q, oe_d;
	logic [8:0]          ad_in_q, ad_in_d;
	logic                hreq_q, hreq_d, rdy_q, rdy_d;
	logic                ext_en, hold_fn, ready_fn, clk_fn, wave_lo, wave_hi;
	logic                single_chip;
	pin_mux_pkg::pin_func_t func [`NPIN];

	assign pin_in = {port9_bits_in, port3_bits_in, port1_bit0_in, port0_bits_in};

	// Function enables from the control register
	assign ext_en      = ctrl_q[`CTRL_EXT_BUS];
	assign single_chip = !ext_en;
	assign hold_fn     = ext_en && ctrl_q[`CTRL_HOLD];
	assign ready_fn    = ext_en && ctrl_q[`CTRL_READY];
	assign clk_fn      = ext_en && ctrl_q[`CTRL_CLKOUT];
	assign wave_lo     = ctrl_q[`CTRL_WAVE_LO];
	assign wave_hi     = ctrl_q[`CTRL_WAVE_HI];

	// AXI4-Lite handshakes
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready  = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always_comb begin
		aw_hs     = s_axi_awvalid && s_axi_awready;
		w_hs      = s_axi_wvalid && s_axi_wready;
		ar_hs     = s_axi_arvalid && s_axi_arready;
		waddr_d   = aw_hs ? s_axi_awaddr[`ADDR_W-1:0] : waddr_q;
		wdata_d   = w_hs ? s_axi_wdata : wdata_q;
		wstrb_d   = w_hs ? s_axi_wstrb : wstrb_q;
		aw_have_d = aw_have_q || aw_hs;
		w_have_d  = w_have_q || w_hs;
		do_wr     = aw_have_d && w_have_d && !bvalid_q;
		wmask     = {{8{wstrb_d[3]}}, {8{wstrb_d[2]}}, {8{wstrb_d[1]}}, {8{wstrb_d[0]}}};
		bvalid_d  = bvalid_q && !s_axi_bready;
		bresp_d   = bresp_q;
		ctrl_d    = ctrl_q;
		data_d    = data_q;
		dir_d     = dir_q;
		pull_d    = pull_q;
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = `RESP_OKAY;
			unique case (waddr_d)
				`REG_CTRL_OFF: ctrl_d = (ctrl_q & ~wmask[`CTRL_W-1:0])
					| (wdata_d[`CTRL_W-1:0] & wmask[`CTRL_W-1:0]);
				`REG_DATA_OFF: data_d = (data_q & ~wmask[`NPIN-1:0])
					| (wdata_d[`NPIN-1:0] & wmask[`NPIN-1:0]);
				`REG_DIR_OFF: dir_d = (dir_q & ~wmask[`NPIN-1:0])
					| (wdata_d[`NPIN-1:0] & wmask[`NPIN-1:0]);
				`REG_PULL_OFF: pull_d = (pull_q & ~wmask[`NPULL-1:0])
					| (wdata_d[`NPULL-1:0] & wmask[`NPULL-1:0]);
				`REG_LEVEL_OFF, `REG_STATUS_OFF: bresp_d = `RESP_OKAY;
				default: bresp_d = `RESP_SLVERR;
			endcase
		end
		rvalid_d = rvalid_q && !s_axi_rready;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rresp_d  = `RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			unique case (s_axi_araddr[`ADDR_W-1:0])
				`REG_CTRL_OFF:   rdata_d[`CTRL_W-1:0] = ctrl_q;
				`REG_DATA_OFF:   rdata_d[`NPIN-1:0] = data_q;
				`REG_DIR_OFF:    rdata_d[`NPIN-1:0] = dir_q;
				`REG_PULL_OFF:   rdata_d[`NPULL-1:0] = pull_q;
				`REG_LEVEL_OFF:  rdata_d[`NPIN-1:0] = pin_in;
				`REG_STATUS_OFF: rdata_d[2:0] = {rdy_q, hold_grant, hreq_q};
				default:         rresp_d = `RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q    <= `CTRL_RST;
			data_q    <= `PIN_RST;
			dir_q     <= `PIN_RST;
			pull_q    <= 13'h0000;
			waddr_q   <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= `RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end else begin
			ctrl_q    <= ctrl_d;
			data_q    <= data_d;
			dir_q     <= dir_d;
			pull_q    <= pull_d;
			waddr_q   <= waddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	// Per-pin function selection and pad drive
	always_comb begin
		for (int i = 0; i < `NPIN; i++) begin
			func[i] = pin_mux_pkg::FUNC_GPIO;
		end
		for (int i = 0; i < 9; i++) begin
			if (ext_en) begin
				func[i] = pin_mux_pkg::FUNC_BUS;
			end
		end
		if (hold_fn) begin
			func[`PIN_HOLD_REQ] = pin_mux_pkg::FUNC_HOLD_IN;
			func[`PIN_HOLD_ACK] = pin_mux_pkg::FUNC_HOLD_ACK;
		end else if (wave_hi) begin
			func[`PIN_HOLD_REQ] = pin_mux_pkg::FUNC_WAVE;
			func[`PIN_HOLD_ACK] = pin_mux_pkg::FUNC_WAVE;
		end
		if (ready_fn) begin
			func[`PIN_READY] = pin_mux_pkg::FUNC_READY;
		end else if (wave_hi) begin
			func[`PIN_READY] = pin_mux_pkg::FUNC_WAVE;
		end
		if (clk_fn) begin
			func[`PIN_CLK] = pin_mux_pkg::FUNC_CLK;
		end else if (wave_hi) begin
			func[`PIN_CLK] = pin_mux_pkg::FUNC_WAVE;
		end
		for (int i = `PIN_P9_LSB; i < `NPIN; i++) begin
			if (wave_lo) begin
				func[i] = pin_mux_pkg::FUNC_WAVE;
			end
		end
		for (int i = 0; i < `NPIN; i++) begin
			out_d[i] = 1'b0;
			oe_d[i]  = 1'b0;
			unique case (func[i])
				pin_mux_pkg::FUNC_GPIO: begin
					out_d[i] = data_q[i];
					oe_d[i]  = dir_q[i];
				end
				pin_mux_pkg::FUNC_BUS: begin
					out_d[i] = bus_ad_out[i % 9];
					oe_d[i]  = bus_ad_oe;
				end
				pin_mux_pkg::FUNC_HOLD_ACK: begin
					out_d[i] = hold_grant;
					oe_d[i]  = 1'b1;
				end
				pin_mux_pkg::FUNC_CLK: begin
					out_d[i] = 1'b0;
					oe_d[i]  = 1'b1;
				end
				pin_mux_pkg::FUNC_WAVE: begin
					out_d[i] = wave_in[(i < `PIN_P9_LSB) ? i - `PIN_HOLD_REQ + 4
						: i - `PIN_P9_LSB];
					oe_d[i]  = 1'b1;
				end
				pin_mux_pkg::FUNC_HOLD_IN, pin_mux_pkg::FUNC_READY: begin
					out_d[i] = 1'b0;
					oe_d[i]  = 1'b0;
				end
			endcase
		end
		ad_in_d = pin_in[8:0];
		hreq_d  = hold_fn && pin_in[`PIN_HOLD_REQ];
		rdy_d   = ready_fn ? pin_in[`PIN_READY] : 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q   <= `PIN_RST;
			oe_q    <= `PIN_RST;
			ad_in_q <= 9'h000;
			hreq_q  <= 1'b0;
			rdy_q   <= 1'b1;
		end else begin
			out_q   <= out_d;
			oe_q    <= oe_d;
			ad_in_q <= ad_in_d;
			hreq_q  <= hreq_d;
			rdy_q   <= rdy_d;
		end
	end

	assign bus_ad_in         = ad_in_q;
	assign hold_request      = hreq_q;
	assign ext_ready         = rdy_q;
	assign port0_bits_out    = out_q[7:0];
	assign port0_bits_oe     = oe_q[7:0];
	assign port1_bit0_out    = out_q[`PIN_P1_0];
	assign port1_bit0_oe     = oe_q[`PIN_P1_0];
	// Clock pin passes the machine clock straight through, not re-registered
	assign port3_bits_out    = {(clk_fn & aclk) | out_q[`PIN_CLK], out_q[11:9]};
	assign port3_bits_oe     = oe_q[12:9];
	assign port9_bits_out    = out_q[16:13];
	assign port9_bits_oe     = oe_q[16:13];
	// Pull-ups only while the pin is in its GPIO role
	assign port0_bits_pullup = single_chip ? pull_q[7:0] : 8'h00;
	assign port1_bit0_pullup = single_chip && pull_q[`PIN_P1_0];
	assign port3_bits_pullup = {pull_q[12] && !clk_fn && !wave_hi,
		pull_q[11] && !ready_fn && !wave_hi,
		pull_q[10:9] & {2{!hold_fn && !wave_hi}}};

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_hold_gpio;
		!hold_fn && !wave_hi |=> port3_bits_oe[1] == $past(dir_q[`PIN_HOLD_ACK])
			&& port3_bits_out[1] == $past(data_q[`PIN_HOLD_ACK]);
	endproperty
	a_hold_gpio: assert property (p_hold_gpio) else $error("hold pin not gpio");
	property p_hold_req;
		(hold_fn |=> hold_request == $past(port3_bits_in[0]) && !port3_bits_oe[0])
			and (!hold_fn |=> !hold_request);
	endproperty
	a_hold_req: assert property (p_hold_req) else $error("hold request wrong");
	property p_hold_ack;
		hold_fn |=> port3_bits_oe[1] && port3_bits_out[1] == $past(hold_grant);
	endproperty
	a_hold_ack: assert property (p_hold_ack) else $error("hold ack not driven");
	property p_ready_in;
		ready_fn ##1 ready_fn |-> ext_ready == $past(port3_bits_in[2]);
	endproperty
	a_ready_in: assert property (p_ready_in) else $error("ready not sampled");
	property p_ready_gpio;
		!ready_fn && !wave_hi |=> ext_ready && port3_bits_oe[2] == $past(dir_q[11]);
	endproperty
	a_ready_gpio: assert property (p_ready_gpio) else $error("ready pin not gpio");
	property p_clk_out;
		clk_fn |=> port3_bits_oe[3];
	endproperty
	a_clk_out: assert property (p_clk_out) else $error("clock pin not driven");
	property p_clk_gpio;
		!clk_fn && !wave_hi ##1 !clk_fn |-> port3_bits_out[3] == $past(data_q[12]);
	endproperty
	a_clk_gpio: assert property (p_clk_gpio) else $error("clock pin not gpio");
	property p_pullup;
		port1_bit0_pullup == (!ext_en && pull_q[8]) && (!ext_en || port0_bits_pullup == 8'h00);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up wrong");
	property p_bus_low;
		ext_en |=> port0_bits_oe == {8{$past(bus_ad_oe)}}
			&& port0_bits_out == $past(bus_ad_out[7:0]);
	endproperty
	a_bus_low: assert property (p_bus_low) else $error("bus low byte wrong");
	property p_bus_bit8;
		ext_en |=> port1_bit0_oe == $past(bus_ad_oe) && port1_bit0_out == $past(bus_ad_out[8]);
	endproperty
	a_bus_bit8: assert property (p_bus_bit8) else $error("bus bit 8 wrong");
	property p_wave;
		wave_lo |=> port9_bits_oe == 4'hF && port9_bits_out == $past(wave_in[3:0]);
	endproperty
	a_wave: assert property (p_wave) else $error("wave outputs wrong");
	property p_default_gpio;
		!ext_en && !wave_lo |=> port9_bits_oe == $past(dir_q[16:13])
			&& port0_bits_oe == $past(dir_q[7:0]);
	endproperty
	a_default_gpio: assert property (p_default_gpio) else $error("default not gpio");

	c_hold: cover property (hold_fn && port3_bits_in[0] ##2 hold_request);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_bus: cover property (ext_en && bus_ad_oe ##1 port0_bits_oe == 8'hFF);

endmodule

// ===== testbench/bus_far_side.sv
// Far-side model: bus peripheral, hold master and ready source at the pads.
// Assumes the bench sets its drive values at the rising clock edge.
`timescale 1ns/1ps

module bus_far_side (
	// Clock
	input	wire logic		aclk,
	// Commands from the bench
	input	wire logic		hold_req_drv,
	input	wire logic		ready_drv,
	input	wire logic [8:0]	bus_drv,
	input	wire logic		bus_drv_en,
	// Device pad drivers
	input	wire logic [7:0]	port0_bits_out,
	input	wire logic [7:0]	port0_bits_oe,
	input	wire logic [7:0]	port0_bits_pullup,
	input	wire logic		port1_bit0_out,
	input	wire logic		port1_bit0_oe,
	input	wire logic		port1_bit0_pullup,
	input	wire logic [3:0]	port3_bits_out,
	input	wire logic [3:0]	port3_bits_oe,
	input	wire logic [3:0]	port3_bits_pullup,
	input	wire logic [3:0]	port9_bits_out,
	input	wire logic [3:0]	port9_bits_oe,
	// Resolved pad levels
	output	logic [7:0]	port0_bits_in,
	output	logic		port1_bit0_in,
	output	logic [3:0]	port3_bits_in,
	output	logic [3:0]	port9_bits_in
);
	logic [16:0]	float_q = 17'h0_aaaa;
	logic [16:0]	dev_oe;
	logic [16:0]	dev_out;
	logic [16:0]	pull;
	logic [16:0]	ext_en;
	logic [16:0]	ext_val;

	// Undriven lines without pull-up wander every cycle
	always @(posedge aclk) float_q <= ~float_q;
	assign dev_oe = {port9_bits_oe, port3_bits_oe, port1_bit0_oe, port0_bits_oe};
	assign dev_out = {port9_bits_out, port3_bits_out, port1_bit0_out, port0_bits_out};
	assign pull = {4'h0, port3_bits_pullup, port1_bit0_pullup, port0_bits_pullup};
	assign ext_en = {4'h0, 1'b0, 1'b1, 1'b0, 1'b1, {9{bus_drv_en}}};
	assign ext_val = {4'h0, 1'b0, ready_drv, 1'b0, hold_req_drv, bus_drv};
	assign {port9_bits_in, port3_bits_in, port1_bit0_in, port0_bits_in} =
		(dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) |
		(~dev_oe & ~ext_en & (pull | float_q));
endmodule

// ===== testbench/bus_port_pin_function_select_bench.sv
// Self-checking bench for the pin-function selector.
// Assumes the far-side model resolves every pad level.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end

module bus_port_pin_function_select_bench;
	logic		aclk = 1'b0, aresetn = 1'b0;
	logic [31:0]	s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
	logic [3:0]	s_axi_wstrb = 4'hf;
	logic		s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic		s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic		s_axi_arready, s_axi_rvalid;
	logic [1:0]	s_axi_bresp, s_axi_rresp, resp;
	logic [8:0]	bus_ad_out = '0, bus_ad_in, bus_drv = '0;
	logic		bus_ad_oe = 0, hold_request, hold_grant = 0, ext_ready, bus_drv_en = 0;
	logic		hold_req_drv = 0, ready_drv = 0;
	logic [7:0]	wave_in = '0, port0_bits_in, port0_bits_out, port0_bits_oe, port0_bits_pullup;
	logic		port1_bit0_in, port1_bit0_out, port1_bit0_oe, port1_bit0_pullup;
	logic [3:0]	port3_bits_in, port3_bits_out, port3_bits_oe, port3_bits_pullup;
	logic [3:0]	port9_bits_in, port9_bits_out, port9_bits_oe;
	int		fail_count = 0, total_checks = 0;

	always #12.5 aclk = ~aclk;

	bus_port_pin_function_select u_bus_port_pin_function_select (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_ad_out, .bus_ad_oe, .bus_ad_in,
		.hold_request, .hold_grant, .ext_ready, .wave_in, .port0_bits_in, .port0_bits_out,
		.port0_bits_oe, .port0_bits_pullup, .port1_bit0_in, .port1_bit0_out,
		.port1_bit0_oe, .port1_bit0_pullup, .port3_bits_in, .port3_bits_out,
		.port3_bits_oe, .port3_bits_pullup, .port9_bits_in, .port9_bits_out, .port9_bits_oe);

	bus_far_side u_bus_far_side (
		.aclk, .hold_req_drv, .ready_drv, .bus_drv, .bus_drv_en, .port0_bits_out,
		.port0_bits_oe, .port0_bits_pullup, .port1_bit0_out, .port1_bit0_oe,
		.port1_bit0_pullup, .port3_bits_out, .port3_bits_oe, .port3_bits_pullup,
		.port9_bits_out, .port9_bits_oe, .port0_bits_in, .port1_bit0_in,
		.port3_bits_in, .port9_bits_in);

	task automatic complete_run();
		$display("checks=%0d errors=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1;
				s_axi_wvalid <= 0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	task automatic settle();
		repeat (2) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic ctrl(input logic [5:0] v);
		axi_wr(`REG_CTRL_OFF, {26'h000_0000, v});
		settle();
	endtask

	task automatic s_reset();
		@(negedge aclk);
		`CHK(port0_bits_oe, 8'h00)
		`CHK(ext_ready, 1'b1)
		`CHK(hold_request, 1'b0)
		axi_rd(`REG_CTRL_OFF);
		`CHK(rd, 32'h0000_0000)
		axi_rd(8'h18);
		`CHK({resp, rd}, {`RESP_SLVERR, 32'h0000_0000})
		axi_wr(8'h18, 32'hffff_ffff);
		`CHK(resp, `RESP_SLVERR)
	endtask

	task automatic s_gpio();
		@(posedge aclk);
		hold_req_drv <= 1;
		axi_wr(`REG_DIR_OFF, 32'h0000_01ff);
		`CHK(resp, `RESP_OKAY)
		axi_wr(`REG_DATA_OFF, 32'h0000_015a);
		axi_wr(`REG_PULL_OFF, 32'h0000_1fff);
		ctrl(6'h0e);
		`CHK({port1_bit0_out, port0_bits_oe, port0_bits_out}, 17'h1_ff5a)
		`CHK({port3_bits_pullup, port1_bit0_pullup, port0_bits_pullup}, 13'h1fff)
		`CHK(port3_bits_oe, 4'h0)
		`CHK(hold_request, 1'b0)
		`CHK(ext_ready, 1'b1)
		axi_rd(`REG_LEVEL_OFF);
		`CHK(rd[9:0], 10'h35a)
	endtask

	task automatic s_bus();
		@(posedge aclk);
		bus_ad_out <= 9'h1a5;
		bus_ad_oe <= 1;
		ctrl(6'h01);
		`CHK({port0_bits_oe, port0_bits_out}, 16'hffa5)
		`CHK({port1_bit0_oe, port1_bit0_out}, 2'h3)
		`CHK(port0_bits_pullup, 8'h00)
		`CHK(hold_request, 1'b0)
		@(posedge aclk);
		bus_ad_oe <= 0;
		bus_drv <= 9'h13c;
		bus_drv_en <= 1;
		settle();
		`CHK(port0_bits_oe, 8'h00)
		`CHK(bus_ad_in, 9'h13c)
	endtask

	task automatic s_hold();
		@(posedge aclk);
		hold_grant <= 1;
		ctrl(6'h03);
		`CHK(hold_request, 1'b1)
		`CHK({port3_bits_oe[1], port3_bits_out[1]}, 2'h3)
		`CHK(port3_bits_pullup[1:0], 2'h0)
		@(posedge aclk);
		hold_grant <= 0;
		hold_req_drv <= 0;
		settle();
		`CHK(hold_request, 1'b0)
		`CHK({port3_bits_oe[1], port3_bits_out[1]}, 2'h2)
		ctrl(6'h02);
		`CHK(port3_bits_oe[1], 1'b0)
	endtask

	task automatic s_ready();
		ctrl(6'h05);
		`CHK(ext_ready, 1'b0)
		@(posedge aclk);
		ready_drv <= 1;
		settle();
		`CHK(ext_ready, 1'b1)
		@(posedge aclk);
		ready_drv <= 0;
		ctrl(6'h04);
		`CHK(ext_ready, 1'b1)
	endtask

	task automatic s_clk_wave();
		ctrl(6'h09);
		`CHK({port3_bits_oe[3], port3_bits_out[3]}, 2'h2)
		@(posedge aclk);
		#2;
		`CHK(port3_bits_out[3], 1'b1)
		axi_wr(`REG_DIR_OFF, 32'h0000_1000);
		ctrl(6'h08);
		@(posedge aclk);
		#2;
		`CHK({port3_bits_oe[3], port3_bits_out[3]}, 2'h2)
		@(posedge aclk);
		wave_in <= 8'hc3;
		ctrl(6'h10);
		`CHK({port9_bits_oe, port9_bits_out}, 8'hf3)
		@(posedge aclk);
		wave_in <= 8'h3c;
		settle();
		`CHK(port9_bits_out, 4'hc)
		ctrl(6'h20);
		`CHK({port3_bits_oe, port3_bits_out}, 8'hf3)
		`CHK(port3_bits_pullup, 4'h0)
		ctrl(6'h00);
		`CHK(port9_bits_oe, 4'h0)
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		s_reset();
		s_gpio();
		s_bus();
		s_hold();
		s_ready();
		s_clk_wave();
		complete_run();
	end

	initial begin
		repeat (3000) @(posedge aclk);
		fail_count++;
		complete_run();
	end
endmodule
